// >>> rtl/nvm_ctrl_defs.vh
// constants shared by the data array controller and its cycle timer
`ifndef NVM_CTRL_DEFS_VH
`define NVM_CTRL_DEFS_VH

`define CLK_MHZ            50
`define PROG_TIME_US       5000
// PROG_TIME_US * CLK_MHZ, sized to the timer so the parameter takes it whole
`define PROG_CYCLES        20'd250000
`define TIMER_W            20

`define ADDR_W             9
`define DATA_W             8
`define ARRAY_DEPTH        256
`define ROW_W              4
`define COL_W              4
`define LATCH_COUNT        16

`define ARRAY_SEL_BIT      8
`define CTRL_OFFSET        9'h100

`define CTRL_RESET         8'h00
`define BIT_PROGRAM        0
`define BIT_LATCH          1
`define BIT_IRQ_EN         2
`define CTRL_RSVD_ZERO     5'h00

`define BYTE_ZERO          8'h00
`define LATCH_NONE         16'h0000

`endif

// >>> rtl/nvm_prog_timer.v
// programming cycle timer: counts a fixed number of clocks, can be frozen
`timescale 1ns/10ps
`default_nettype none
`include "nvm_ctrl_defs.vh"

module nvm_prog_timer #(
    parameter [`TIMER_W-1:0] TERM = `PROG_CYCLES
) (
    input  wire CLK,
    input  wire RST,
    input  wire start,
    input  wire abort,
    input  wire hold,
    output reg  busy,
    output reg  done
);

    reg [`TIMER_W-1:0] count;

    always @(posedge CLK) begin
        if (RST) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            count <= {`TIMER_W{1'b0}};
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy  <= 1'b0;
                count <= {`TIMER_W{1'b0}};
            end else if (start && !busy) begin
                busy  <= 1'b1;
                count <= {`TIMER_W{1'b0}};
            end else if (busy && !hold) begin
                // a frozen cycle resumes where it stopped; the row may be damaged
                if (count == TERM - 1'b1) begin
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    count <= {`TIMER_W{1'b0}};
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> rtl/data_nvm_ctrl.v
// data array controller: read path, row latches, timed row programming
`timescale 1ns/10ps
`default_nettype none
`include "nvm_ctrl_defs.vh"

module data_nvm_ctrl #(
    parameter [`TIMER_W-1:0] PROG_CYCLES = `PROG_CYCLES
) (
    input  wire               CLK,
    input  wire               RST,
    input  wire [`ADDR_W-1:0] ADDR,
    input  wire [`DATA_W-1:0] WDATA,
    input  wire               WR,
    input  wire               RD,
    output reg  [`DATA_W-1:0] RDATA,
    output reg                RDATA_OE,
    input  wire               WAIT_REQ,
    input  wire               HALT_REQ,
    input  wire               IRQ_ACK,
    output reg                IRQ,
    output reg                WAKE,
    output reg                WAIT_ACTIVE,
    output reg                HALT_ACTIVE,
    output reg                BUSY
);

    reg  [`DATA_W-1:0]      array_mem [0:`ARRAY_DEPTH-1];
    reg  [`DATA_W-1:0]      latch_data [0:`LATCH_COUNT-1];
    reg  [`LATCH_COUNT-1:0] latch_valid;
    reg  [`ROW_W-1:0]       row;

    reg                     done_irq_enable;
    reg                     latch_mode;
    reg                     program_start;
    reg                     irq_pending;

    reg                     next_latch_mode;
    reg                     next_program_start;
    reg                     start_cycle;
    reg                     abort_cycle;
    reg                     clear_latches;

    wire                    timer_busy;
    wire                    timer_done;

    wire                    is_array;
    wire                    is_ctrl;
    wire                    ctrl_wr;
    wire                    array_wr;
    wire [`COL_W-1:0]       col;
    wire [`DATA_W-1:0]      ctrl_value;

    integer                 i;
    integer                 j;

    localparam [`DATA_W-1:0] CTRL_INIT = `CTRL_RESET;

    assign is_array   = ~ADDR[`ARRAY_SEL_BIT];
    assign is_ctrl    = (ADDR == `CTRL_OFFSET);
    assign ctrl_wr    = WR && is_ctrl;
    assign array_wr   = WR && is_array;
    assign col        = ADDR[`COL_W-1:0];
    assign ctrl_value = {`CTRL_RSVD_ZERO, done_irq_enable, latch_mode, program_start};

    nvm_prog_timer #(
        .TERM (PROG_CYCLES)
    ) u_timer (
        .CLK   (CLK),
        .RST   (RST),
        .start (start_cycle),
        .abort (abort_cycle),
        .hold  (HALT_ACTIVE),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    // next state of the two mode bits; the hardware end of a cycle beats any
    // software write landing in the same clock
    always @* begin
        next_latch_mode    = latch_mode;
        next_program_start = program_start;
        start_cycle        = 1'b0;
        abort_cycle        = 1'b0;
        if (ctrl_wr) begin
            if (WDATA[`BIT_LATCH]) begin
                next_latch_mode = 1'b1;
            end else if (!program_start) begin
                next_latch_mode = 1'b0;
            end
            if (WDATA[`BIT_PROGRAM] && !program_start && next_latch_mode) begin
                next_program_start = 1'b1;
                start_cycle        = 1'b1;
            end else if (!WDATA[`BIT_PROGRAM] && program_start) begin
                // software abort: the row is left untouched and not trusted
                next_program_start = 1'b0;
                abort_cycle        = 1'b1;
            end
        end
        if (timer_done) begin
            next_program_start = 1'b0;
            next_latch_mode    = 1'b0;
        end
    end

    always @* begin
        clear_latches = timer_done || (latch_mode && !next_latch_mode);
    end

    // control register
    always @(posedge CLK) begin
        if (RST) begin
            done_irq_enable <= CTRL_INIT[`BIT_IRQ_EN];
            latch_mode      <= CTRL_INIT[`BIT_LATCH];
            program_start   <= CTRL_INIT[`BIT_PROGRAM];
        end else begin
            if (ctrl_wr) begin
                done_irq_enable <= WDATA[`BIT_IRQ_EN];
            end
            latch_mode    <= next_latch_mode;
            program_start <= next_program_start;
        end
    end

    // row latches; a write that misses latch mode leaves them alone
    always @(posedge CLK) begin
        if (RST) begin
            latch_valid <= `LATCH_NONE;
            row         <= {`ROW_W{1'b0}};
            for (i = 0; i < `LATCH_COUNT; i = i + 1) begin
                latch_data[i] <= `BYTE_ZERO;
            end
        end else if (clear_latches) begin
            latch_valid <= `LATCH_NONE;
            for (i = 0; i < `LATCH_COUNT; i = i + 1) begin
                latch_data[i] <= `BYTE_ZERO;
            end
        end else if (array_wr && latch_mode) begin
            row <= ADDR[`COL_W+`ROW_W-1:`COL_W];
            latch_valid[col] <= 1'b1;
            if (latch_valid[col]) begin
                // repeated write over-programs: cells only ever lose ones
                latch_data[col] <= latch_data[col] & WDATA;
            end else begin
                latch_data[col] <= WDATA;
            end
        end
    end

    // commit of the latched bytes into the row when the timer expires;
    // the array has no reset, like the cells it stands for
    always @(posedge CLK) begin
        if (!RST && timer_done) begin
            for (j = 0; j < `LATCH_COUNT; j = j + 1) begin
                if (latch_valid[j]) begin
                    array_mem[{row, j[`COL_W-1:0]}] <= latch_data[j];
                end
            end
        end
    end

    // read port: data stand for one cycle after the strobe; latches are
    // never on the read mux
    always @(posedge CLK) begin
        if (RST) begin
            RDATA    <= `BYTE_ZERO;
            RDATA_OE <= 1'b0;
        end else if (RD) begin
            if (is_array) begin
                if (latch_mode) begin
                    RDATA    <= `BYTE_ZERO;
                    RDATA_OE <= 1'b0;
                end else begin
                    RDATA    <= array_mem[ADDR[`ROW_W+`COL_W-1:0]];
                    RDATA_OE <= 1'b1;
                end
            end else if (is_ctrl) begin
                RDATA    <= ctrl_value;
                RDATA_OE <= 1'b1;
            end else begin
                RDATA    <= `BYTE_ZERO;
                RDATA_OE <= 1'b1;
            end
        end else begin
            RDATA    <= `BYTE_ZERO;
            RDATA_OE <= 1'b0;
        end
    end

    // end-of-cycle request; a new event beats the acknowledge
    always @(posedge CLK) begin
        if (RST) begin
            irq_pending <= 1'b0;
        end else if (timer_done && done_irq_enable) begin
            irq_pending <= 1'b1;
        end else if (IRQ_ACK) begin
            irq_pending <= 1'b0;
        end
    end

    // low power states; wait is held off while a cycle runs
    always @(posedge CLK) begin
        if (RST) begin
            WAIT_ACTIVE <= 1'b0;
            HALT_ACTIVE <= 1'b0;
            WAKE        <= 1'b0;
        end else begin
            HALT_ACTIVE <= HALT_REQ;
            if (!WAIT_REQ) begin
                WAIT_ACTIVE <= 1'b0;
            end else if (!timer_busy && !program_start && !start_cycle) begin
                // wait only once the program bit has dropped: the cycle is over
                WAIT_ACTIVE <= 1'b1;
            end
            // halt swallows the wake pulse: the timer is frozen anyway
            WAKE <= WAIT_ACTIVE && !HALT_ACTIVE && timer_done && done_irq_enable;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            IRQ  <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            IRQ  <= (irq_pending && !IRQ_ACK) || (timer_done && done_irq_enable);
            BUSY <= next_program_start;
        end
    end

endmodule
`default_nettype wire

// >>> verif/data_nvm_ctrl_sva.sv
// port-level checks for the data array controller
`timescale 1ns/10ps
`default_nettype none
`include "nvm_ctrl_defs.vh"
module data_nvm_ctrl_sva (
    input wire               CLK,
    input wire               RST,
    input wire               RD,
    input wire [`DATA_W-1:0] RDATA,
    input wire               RDATA_OE,
    input wire               IRQ_ACK,
    input wire               IRQ,
    input wire               WAKE,
    input wire               WAIT_REQ,
    input wire               WAIT_ACTIVE,
    input wire               HALT_REQ,
    input wire               HALT_ACTIVE,
    input wire               BUSY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_rd_idle; !RD |=> !RDATA_OE && RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read bus driven without read");
    property p_irq_src; $rose(IRQ) |-> $fell(BUSY); endproperty
    a_irq_src: assert property (p_irq_src) else $error("request without cycle end");
    property p_irq_ack; IRQ && IRQ_ACK |=> !IRQ || $fell(BUSY); endproperty
    a_irq_ack: assert property (p_irq_ack) else $error("request kept after service");
    property p_wake; WAKE |-> IRQ && $fell(BUSY) && $past(WAIT_ACTIVE) ##1 !WAKE; endproperty
    a_wake: assert property (p_wake) else $error("bad wake pulse");
    property p_wake_halt; $past(HALT_ACTIVE) |-> !WAKE; endproperty
    a_wake_halt: assert property (p_wake_halt) else $error("wake while halted");
    property p_wait_idle; WAIT_REQ && !BUSY |=> WAIT_ACTIVE; endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("idle wait not entered");
    property p_wait_busy; $rose(WAIT_ACTIVE) |-> !$past(BUSY); endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("wait entered mid cycle");
    property p_halt; HALT_REQ |=> HALT_ACTIVE; endproperty
    a_halt: assert property (p_halt) else $error("halt not entered");
    property p_halt_hold; BUSY && HALT_ACTIVE && $past(HALT_ACTIVE) |=> BUSY; endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("cycle ran on in halt");
endmodule
bind data_nvm_ctrl data_nvm_ctrl_sva chk (.CLK(CLK), .RST(RST), .RD(RD), .RDATA(RDATA),
    .RDATA_OE(RDATA_OE), .IRQ_ACK(IRQ_ACK), .IRQ(IRQ), .WAKE(WAKE), .WAIT_REQ(WAIT_REQ),
    .WAIT_ACTIVE(WAIT_ACTIVE), .HALT_REQ(HALT_REQ), .HALT_ACTIVE(HALT_ACTIVE), .BUSY(BUSY));
`default_nettype wire

// >>> verif/cpu_bus_model.sv
// cpu side master of the array and control port
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
    input  wire        CLK,
    output logic [8:0] ADDR,
    output logic [7:0] WDATA,
    output logic       WR,
    output logic       RD,
    input  wire  [7:0] RDATA,
    input  wire        RDATA_OE
);
    initial begin
        ADDR = 9'h000;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
    end
    // data accesses only, never a fetch one row per cycle never aborts
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        WDATA <= ~d;
        #1;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic oe);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
        oe = RDATA_OE;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_data_nvm_ctrl.sv
// self-checking bench for the data array controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", n, e, v); end end
module tb_data_nvm_ctrl;
    logic       CLK = 1'b0;
    logic       RST = 1'b1;
    logic       WAIT_REQ = 1'b0;
    logic       HALT_REQ = 1'b0;
    logic       IRQ_ACK = 1'b0;
    wire  [8:0] ADDR;
    wire  [7:0] WDATA, RDATA;
    wire        WR, RD, RDATA_OE, IRQ, WAKE, WAIT_ACTIVE, HALT_ACTIVE, BUSY;
    int         failures = 0;
    int         compares = 0;
    int         cyc = 0;
    int         n;
    logic [7:0] d;
    logic       oe, w;
    always #10 CLK = ~CLK;
    cpu_bus_model cpu (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .RDATA_OE(RDATA_OE));
    data_nvm_ctrl #(.PROG_CYCLES(20'd8)) DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .RDATA_OE(RDATA_OE), .WAIT_REQ(WAIT_REQ),
        .HALT_REQ(HALT_REQ), .IRQ_ACK(IRQ_ACK), .IRQ(IRQ), .WAKE(WAKE),
        .WAIT_ACTIVE(WAIT_ACTIVE), .HALT_ACTIVE(HALT_ACTIVE), .BUSY(BUSY));
    task automatic rdc(input logic [8:0] a, input logic [7:0] e, input logic eo);
        cpu.rd(a, d, oe);
        `CHK("rdata", e, d)
        `CHK("rdata_oe", eo, oe)
    endtask
    task automatic prog(input logic [8:0] a, input logic [7:0] v, input logic [7:0] c);
        cpu.wr(9'h100, 8'h02);
        cpu.wr(a, v);
        cpu.wr(9'h100, c);
    endtask
    // counts cycles until the busy flag drops, noting any wake pulse
    task automatic run();
        n = 0;
        w = 1'b0;
        while (BUSY !== 1'b0 && n < 100) begin
            @(posedge CLK);
            #1;
            n++;
            w = w | WAKE;
        end
        `CHK("busy", 1'b0, BUSY)
    endtask
    task automatic ack();
        @(posedge CLK);
        IRQ_ACK <= 1'b1;
        @(posedge CLK);
        IRQ_ACK <= 1'b0;
        #1;
        `CHK("irq", 1'b0, IRQ)
    endtask
    task automatic t_regs();
        rdc(9'h100, 8'h00, 1'b1);
        cpu.wr(9'h100, 8'hF8);
        rdc(9'h100, 8'h00, 1'b1);
        cpu.wr(9'h100, 8'h04);
        rdc(9'h100, 8'h04, 1'b1);
        cpu.wr(9'h100, 8'h00);
        rdc(9'h1FF, 8'h00, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_prog();
        cpu.wr(9'h100, 8'h02);
        cpu.wr(9'h035, 8'hA5);
        cpu.wr(9'h035, 8'h3C);
        cpu.wr(9'h03A, 8'h5A);
        rdc(9'h035, 8'h00, 1'b0);
        cpu.wr(9'h100, 8'h07);
        rdc(9'h100, 8'h07, 1'b1);
        run();
        `CHK("cycle length", 1'b1, n >= 6 && n <= 8)
        `CHK("irq", 1'b1, IRQ)
        rdc(9'h100, 8'h04, 1'b1);
        rdc(9'h035, 8'h24, 1'b1);
        rdc(9'h03A, 8'h5A, 1'b1);
        ack();
        $display("test prog done");
    endtask
    task automatic t_ignore();
        cpu.wr(9'h035, 8'hFF);
        prog(9'h031, 8'h11, 8'h03);
        run();
        `CHK("irq", 1'b0, IRQ)
        rdc(9'h035, 8'h24, 1'b1);
        rdc(9'h031, 8'h11, 1'b1);
        $display("test ignore done");
    endtask
    task automatic t_wait();
        prog(9'h032, 8'h33, 8'h07);
        @(posedge CLK);
        WAIT_REQ <= 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        `CHK("wait_active", 1'b0, WAIT_ACTIVE)
        run();
        `CHK("wake", 1'b0, w)
        @(posedge CLK);
        #1;
        `CHK("wait_active", 1'b1, WAIT_ACTIVE)
        ack();
        prog(9'h033, 8'h44, 8'h07);
        run();
        `CHK("wake", 1'b1, w)
        @(posedge CLK);
        WAIT_REQ <= 1'b0;
        ack();
        `CHK("wait_active", 1'b0, WAIT_ACTIVE)
        $display("test wait done");
    endtask
    task automatic t_halt();
        prog(9'h034, 8'h55, 8'h03);
        @(posedge CLK);
        HALT_REQ <= 1'b1;
        repeat (20) @(posedge CLK);
        #1;
        `CHK("busy", 1'b1, BUSY)
        `CHK("halt_active", 1'b1, HALT_ACTIVE)
        cpu.wr(9'h100, 8'h01);
        rdc(9'h100, 8'h03, 1'b1);
        @(posedge CLK);
        HALT_REQ <= 1'b0;
        run();
        rdc(9'h100, 8'h00, 1'b1);
        $display("test halt done");
    endtask
    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        t_regs();
        t_prog();
        t_ignore();
        t_wait();
        t_halt();
        report_and_stop();
    end
endmodule
`default_nettype wire
